// >>> rtl/mcuex_regs.svh
`ifndef MCUEX_REGS_SVH
`define MCUEX_REGS_SVH

// ==========================================
// instruction word fields
`define MCUEX_OP_MSB        4'hF
`define MCUEX_OP_LSB        4'hB
`define MCUEX_BIT_MSB       4'hA
`define MCUEX_BIT_LSB       4'h8

// ==========================================
// data memory special locations
`define MCUEX_PORT_ADDR     5'h00
`define MCUEX_PC_LOW_ADDR   5'h02
`define MCUEX_TBLP_ADDR     5'h03
`define MCUEX_TBLH_ADDR     5'h04

// ==========================================
// timing and reset values
`define MCUEX_CLKS_PER_ICYC 3'h4
`define MCUEX_PHASE_LAST    2'h3
`define MCUEX_PC_RESET      11'h000
`define MCUEX_BYTE_RESET    8'h00

`endif

// >>> rtl/mcuex_pkg.sv
`default_nettype none

package mcuex_pkg;

	// ==========================================
	// operation codes, taken from word bits 15..11
	typedef enum logic [4:0] {
		OP_NOP, OP_XFER_A_M, OP_XFER_M_A, OP_XFER_A_X,
		OP_ADD_M, OP_ADD_X, OP_SUB_M, OP_SUB_X,
		OP_INC_M, OP_INC_ACC, OP_DECR_M, OP_DECR_ACC,
		OP_AND_M, OP_OR_M, OP_XOR_M, OP_COMPL_M,
		OP_ROR_M, OP_ROL_M, OP_RORC_M, OP_ROLC_M,
		OP_SKZ_M, OP_SKBZ_M, OP_SET_BIT, OP_CLR_BIT,
		OP_JUMP, OP_CALL, OP_RETURN, OP_INT_RETURN, OP_TABRD
	} mcuex_op_type;

	// ==========================================
	// instruction cycle kind
	typedef enum logic {
		ST_EXEC,
		ST_EXTRA
	} mcuex_state_type;

	// ==========================================
	// visible core state
	typedef struct packed {
		logic [7:0]  acc;
		logic        carry;
		logic        zero;
		logic        gie;
		logic [10:0] pc;
		logic [7:0]  port;
		logic        retire;
	} mcuex_status_type;

	// ==========================================
	// complete core state
	typedef struct packed {
		mcuex_state_type   state;
		logic [1:0]        phase;
		logic [10:0]       fetch_addr;
		logic              tbl_pending;
		logic [4:0]        tbl_dst;
		logic [2:0]        sp;
		logic [7:0][10:0]  stack;
		logic [31:0][7:0]  dmem;
		mcuex_status_type  st;
	} mcuex_core_type;

endpackage : mcuex_pkg

`default_nettype wire

// >>> rtl/mcuex_core.sv
`timescale 1ns/10ps
`include "mcuex_regs.svh"
`default_nettype none

module mcuex_core
	import mcuex_pkg::*;
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// program memory
	output logic      [10:0]       prog_addr,
	input  wire logic [15:0]       prog_data,
	// core state
	output mcuex_status_type       status
);

	// ==========================================
	// helpers
	// 9-bit add or subtract; bit 8 is carry or borrow
	function automatic logic [8:0] addsub(input logic [7:0] a, input logic [7:0] b, input logic sub);
		if (sub) begin
			addsub = {1'b0, a} - {1'b0, b};
		end else begin
			addsub = {1'b0, a} + {1'b0, b};
		end
	endfunction : addsub

	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == `MCUEX_BYTE_RESET);
	endfunction : is_zero

	// ==========================================
	// state
	mcuex_core_type r_q;
	mcuex_core_type r_d;

	mcuex_op_type op;
	logic [4:0]   m;
	logic [2:0]   bsel;
	logic [7:0]   x;
	logic [7:0]   mv;
	logic [7:0]   wv;
	logic         wr;
	logic         extra;
	logic         skip;
	logic [8:0]   res;
	logic [10:0]  pc1;

	// ==========================================
	// next state; work happens only on the last phase, so each cycle spans four clocks
	always_comb begin
		r_d = r_q;
		r_d.st.retire = 1'b0;
		r_d.phase = r_q.phase + 2'h1;
		op = mcuex_op_type'(prog_data[`MCUEX_OP_MSB:`MCUEX_OP_LSB]);
		m = prog_data[4:0];
		bsel = prog_data[`MCUEX_BIT_MSB:`MCUEX_BIT_LSB];
		x = prog_data[7:0];
		// the low pc byte reads back through its memory slot
		mv = (m == `MCUEX_PC_LOW_ADDR) ? r_q.st.pc[7:0] : r_q.dmem[m];
		wv = mv;
		wr = 1'b0;
		extra = 1'b0;
		skip = 1'b0;
		res = 9'h000;
		pc1 = r_q.st.pc + 11'h001;
		if (r_q.phase == `MCUEX_PHASE_LAST) begin
			unique case (r_q.state)
				ST_EXEC: begin
					r_d.st.pc = pc1;
					unique case (op)
						OP_NOP: begin
						end
						OP_XFER_A_M: r_d.st.acc = mv;
						OP_XFER_M_A: begin
							wr = 1'b1;
							wv = r_q.st.acc;
						end
						OP_XFER_A_X: r_d.st.acc = x;
						OP_ADD_M, OP_ADD_X, OP_SUB_M, OP_SUB_X: begin
							res = addsub(r_q.st.acc, (op == OP_ADD_X || op == OP_SUB_X) ? x : mv,
								(op == OP_SUB_M || op == OP_SUB_X));
							r_d.st.acc = res[7:0];
							r_d.st.carry = res[8];
							r_d.st.zero = is_zero(res[7:0]);
						end
						OP_INC_M, OP_INC_ACC, OP_DECR_M, OP_DECR_ACC: begin
							res = addsub(mv, 8'h01, (op == OP_DECR_M || op == OP_DECR_ACC));
							r_d.st.zero = is_zero(res[7:0]);
							if (op == OP_INC_ACC || op == OP_DECR_ACC) begin
								r_d.st.acc = res[7:0];
							end else begin
								wr = 1'b1;
								wv = res[7:0];
							end
						end
						OP_AND_M, OP_OR_M, OP_XOR_M: begin
							res[7:0] = (op == OP_AND_M) ? (r_q.st.acc & mv) :
								(op == OP_OR_M) ? (r_q.st.acc | mv) : (r_q.st.acc ^ mv);
							r_d.st.acc = res[7:0];
							r_d.st.zero = is_zero(res[7:0]);
						end
						OP_COMPL_M: begin
							wr = 1'b1;
							wv = ~mv;
							r_d.st.zero = is_zero(~mv);
						end
						OP_ROR_M: begin
							wr = 1'b1;
							wv = {mv[0], mv[7:1]};
						end
						OP_ROL_M: begin
							wr = 1'b1;
							wv = {mv[6:0], mv[7]};
						end
						OP_RORC_M: begin
							wr = 1'b1;
							wv = {r_q.st.carry, mv[7:1]};
							r_d.st.carry = mv[0];
						end
						OP_ROLC_M: begin
							wr = 1'b1;
							wv = {mv[6:0], r_q.st.carry};
							r_d.st.carry = mv[7];
						end
						OP_SKZ_M: skip = is_zero(mv);
						OP_SKBZ_M: skip = !mv[bsel];
						OP_SET_BIT: begin
							wr = 1'b1;
							wv = mv | (8'h01 << bsel);
						end
						OP_CLR_BIT: begin
							wr = 1'b1;
							wv = mv & ~(8'h01 << bsel);
						end
						OP_JUMP: begin
							r_d.st.pc = prog_data[10:0];
							extra = 1'b1;
						end
						OP_CALL: begin
							r_d.stack[r_q.sp] = pc1;
							r_d.sp = r_q.sp + 3'h1;
							r_d.st.pc = prog_data[10:0];
							extra = 1'b1;
						end
						OP_RETURN, OP_INT_RETURN: begin
							r_d.sp = r_q.sp - 3'h1;
							r_d.st.pc = r_q.stack[r_q.sp - 3'h1];
							r_d.st.gie = (op == OP_INT_RETURN) ? 1'b1 : r_q.st.gie;
							extra = 1'b1;
						end
						OP_TABRD: begin
							r_d.tbl_pending = 1'b1;
							r_d.tbl_dst = m;
							extra = 1'b1;
						end
						default: begin
						end
					endcase
					// skip lands past the next word and costs the extra cycle
					if (skip) begin
						r_d.st.pc = r_q.st.pc + 11'h002;
						extra = 1'b1;
					end
					if (wr) begin
						if (m == `MCUEX_PC_LOW_ADDR) begin
							r_d.st.pc = {pc1[10:8], wv};
							extra = 1'b1;
						end else begin
							r_d.dmem[m] = wv;
						end
					end
					r_d.state = extra ? ST_EXTRA : ST_EXEC;
					r_d.st.retire = !extra;
					// table fetch uses the page of the next instruction
					r_d.fetch_addr = r_d.tbl_pending ?
						{pc1[10:8], r_q.dmem[`MCUEX_TBLP_ADDR]} : r_d.st.pc;
				end
				ST_EXTRA: begin
					// low byte to the named slot unless that is the pc low slot, high byte to the table-high slot
					if (r_q.tbl_pending) begin
						if (r_q.tbl_dst != `MCUEX_PC_LOW_ADDR) begin
							r_d.dmem[r_q.tbl_dst] = prog_data[7:0];
						end
						r_d.dmem[`MCUEX_TBLH_ADDR] = prog_data[15:8];
					end
					r_d.tbl_pending = 1'b0;
					r_d.state = ST_EXEC;
					r_d.st.retire = 1'b1;
					r_d.fetch_addr = r_q.st.pc;
				end
			endcase
		end
		r_d.st.port = r_d.dmem[`MCUEX_PORT_ADDR];
	end

	// ==========================================
	// registers
	always_ff @(posedge clock) begin
		if (rst) begin
			r_q <= '0;
			r_q.state <= ST_EXEC;
			r_q.fetch_addr <= `MCUEX_PC_RESET;
			r_q.st.pc <= `MCUEX_PC_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// ==========================================
	// outputs straight from flops
	assign prog_addr = r_q.fetch_addr;
	assign status = r_q.st;

endmodule : mcuex_core

`default_nettype wire

// >>> dv/mcuex_prog_mem.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// program memory holding code and table words
module mcuex_prog_mem (
	// fetch side
	input  wire logic        clock,
	input  wire logic [10:0] addr,
	output logic      [15:0] data
);
	logic [15:0] words [2048];

	// empty memory reads as no-operation words
	initial foreach (words[i]) words[i] = 16'h0000;

	// one clock of latency, inside what the core tolerates
	always_ff @(posedge clock) data <= words[addr];
endmodule : mcuex_prog_mem

`default_nettype wire

// >>> dv/mcuex_core_sva.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// sequencing checks on the core outputs
module mcuex_core_sva
	import mcuex_pkg::*;
(
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst,
	// watched outputs
	input  wire logic [10:0]      prog_addr,
	input  wire mcuex_status_type status
);
	logic r;

	// completion pulse alone, for short properties
	assign r = status.retire;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	a_addr_holds: assert property ($changed(prog_addr) |=> $stable(prog_addr)[*3])
		else $error("fetch address moved inside a cycle");
	a_retire_gap: assert property (r |=> !r[*3])
		else $error("completions closer than four clocks");
	a_retire_next: assert property (r |-> (##4 r) or (##8 r))
		else $error("instruction took neither one nor two cycles");
	a_state_moves: assert property ($changed({status.acc, status.carry, status.zero, status.port}) |-> r)
		else $error("state changed without a completion");
	a_gie_sticky: assert property ($past(status.gie) |-> status.gie)
		else $error("interrupt enable dropped");
	a_pc_step: assert property (r && $past(r, 4) |-> status.pc == $past(status.pc, 4) + 11'h001)
		else $error("short instruction did not step by one");
	a_addr_pc: assert property (r |-> prog_addr == status.pc)
		else $error("fetch address differs from pc");
	a_reset_quiet: assert property ($fell(rst) |-> !r[*4])
		else $error("completion too soon after reset");

	c_short: cover property (r ##4 r);
	c_long: cover property (r ##8 r);
	c_gie: cover property ($rose(status.gie));
endmodule : mcuex_core_sva

`default_nettype wire

// >>> dv/mcuex_core_bench.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// random program run against a reference model
module mcuex_core_bench
	import mcuex_pkg::*;
;
	logic             clock, rst;
	logic [10:0]      prog_addr, pc;
	logic [15:0]      prog_data, w;
	mcuex_status_type status, exp_st;
	logic [31:0]      seed;
	int               num_errors, checked;
	logic [7:0]       a, p0, p3, p4, n, e;
	logic             c, z, g;
	logic [10:0]      stk [8];
	logic [2:0]       sp;
	logic [15:0]      cw [5] = '{16'h2801, 16'h3801, 16'hA000, 16'h1002, 16'hD800};

	mcuex_core dut (.clock(clock), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data), .status(status));
	mcuex_prog_mem mem (.clock(clock), .addr(prog_addr), .data(prog_data));

	// free-running system clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	function automatic logic [31:0] nx(input logic [31:0] s);
		nx = {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
	endfunction : nx

	// memory operands use byte 0 so results show on the port; stores also hit the pc low and table pointer slots
	function automatic logic [15:0] gen(input logic [31:0] r);
		gen = r[15:0];
		if (!(r[15:11] inside {5'd3, 5'd5, 5'd7, 5'd24, 5'd25})) gen[4:0] = 5'h00;
		if (r[15:11] == 5'd2 && r[16]) gen[4:0] = r[17] ? 5'h02 : 5'h03;
		// loads also read the pc low slot and the table high slot
		if (r[15:11] == 5'd1 && r[16]) gen[4:0] = r[17] ? 5'h02 : 5'h04;
	endfunction : gen

	task automatic cmp_st(input mcuex_status_type got, input mcuex_status_type want);
		checked++;
		if (got !== want) begin
			num_errors++;
			$display("unexpected status at %0t: got %h want %h", $time, got, want);
		end
	endtask : cmp_st

	task automatic cmp_n(input logic [7:0] got, input logic [7:0] want);
		checked++;
		if (got !== want) begin
			num_errors++;
			$display("unexpected clock count at %0t: got %h want %h", $time, got, want);
		end
	endtask : cmp_n

	task automatic conclude();
		$display("errors %0d comparisons %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// reference model: effect of one word and its length in clocks
	task automatic exe(input logic [15:0] i);
		logic [10:0] np;
		logic [8:0]  t;
		logic [7:0]  x;
		np = pc + 11'h001;
		x = (i[15:11] == 5'd4 || i[15:11] == 5'd6) ? p0 : i[7:0];
		e = 8'h04;
		case (i[15:11])
			5'd1: a = (i[4:0] == 5'h04) ? p4 : (i[4:0] == 5'h02) ? pc[7:0] : p0;
			5'd2: if (i[4:0] == 5'h02) begin np = {np[10:8], a}; e = 8'h08; end
				else if (i[4:0] == 5'h03) p3 = a;
				else p0 = a;
			5'd3: a = i[7:0];
			5'd4, 5'd5, 5'd6, 5'd7: begin t = i[12] ? {1'b0, a} - {1'b0, x} : {1'b0, a} + {1'b0, x};
				a = t[7:0]; c = t[8]; z = (a == 8'h00); end
			5'd8, 5'd9, 5'd10, 5'd11: begin x = i[12] ? p0 - 8'h01 : p0 + 8'h01;
				if (i[11]) a = x; else p0 = x; z = (x == 8'h00); end
			5'd12: begin a = a & p0; z = (a == 8'h00); end
			5'd13: begin a = a | p0; z = (a == 8'h00); end
			5'd14: begin a = a ^ p0; z = (a == 8'h00); end
			5'd15: begin p0 = ~p0; z = (p0 == 8'h00); end
			5'd16: p0 = {p0[0], p0[7:1]};
			5'd17: p0 = {p0[6:0], p0[7]};
			5'd18: {p0, c} = {c, p0};
			5'd19: {c, p0} = {p0, c};
			5'd20, 5'd21: if (i[11] ? !p0[i[10:8]] : p0 == 8'h00) begin np++; e = 8'h08; end
			5'd22, 5'd23: p0[i[10:8]] = !i[11];
			5'd24: begin np = i[10:0]; e = 8'h08; end
			5'd25: begin stk[sp] = np; sp++; np = i[10:0]; e = 8'h08; end
			5'd26, 5'd27: begin sp--; np = stk[sp]; e = 8'h08; g = g | i[11]; end
			5'd28: begin
				p0 = mem.words[{np[10:8], p3}][7:0];
				p4 = mem.words[{np[10:8], p3}][15:8];
				e = 8'h08;
			end
			default: ;
		endcase
		pc = np;
	endtask : exe

	// main sequence: corner words first, then random ones
	initial begin
		rst = 1'b1;
		{num_errors, checked, seed} = {32'h0, 32'h0, 32'h0000_1917};
		{a, c, z, g, pc, p0, p3, p4, sp} = '0;
		foreach (stk[i]) stk[i] = 11'h000;
		w = 16'h18FF;
		repeat (20) @(negedge clock);
		mem.words[0] = w;
		rst = 1'b0;
		for (int k = 0; k < 700; k++) begin
			exe(w);
			n = 8'h00;
			do begin
				@(negedge clock);
				n++;
			end while (status.retire !== 1'b1 && n < 8'd20);
			if (n == 8'd20) begin
				num_errors++;
				conclude();
			end
			cmp_n(n, e);
			exp_st = {a, c, z, g, pc, p0, 1'b1};
			cmp_st(status, exp_st);
			seed = nx(seed);
			w = (k < 5) ? cw[k] : gen(seed);
			mem.words[pc] = w;
		end
		conclude();
	end
endmodule : mcuex_core_bench

bind mcuex_core mcuex_core_sva chk (.clock(clock), .rst(rst), .prog_addr(prog_addr), .status(status));

`default_nettype wire
